// >>> core/pwc_channel.v
// Function
// (RULE1) dead band 10 to 80 ns by code; code rounds every code up to one 100 ns clock
// (RULE2) mode 0: duty to 0%, A>B
// (RULE3) mode 1: duty to 100%, A>=B
// (RULE4) function bit: modulator or comparator output
// (RULE5) clock source and clock inversion select
// (RULE6) async power-down forces output low
// (RULE7) sync power-down: clock back after two cycles
// (RULE8) sync power-down: gate clock, hold output
// (RULE9) force-on bit overrides matrix power-down
// (RULE10) positive operand source select
// (RULE11) programmed 8-bit operand constant
// (RULE12) serial port buffers ADC, one clock delay; code delays it two clocks via adc_q
// (RULE13) parallel load source: counts or ADC
// (RULE14) configurable serial clock phase
// (RULE15) configurable serial clock idle level
// (RULE16) transfer length 16 or 8 bits
// (RULE17) direction: serial-in or parallel-in
// (RULE18) shared clock mux four sources
// (RULE19) operand sync to serial clock option
// (RULE20) both outputs low during dead band
// (RULE21) 256-clock period, high below operand; code in mode 1 also stays high at the operand (cnt <= op)
// (RULE22) master holds select for whole transfer
`include "pwc_map.vh"

module pwc_channel
(
    input wire MCLK,
    input wire RSTN,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire [7:0] ADC_RESULT,
    input wire [7:0] STATE_MACHINE_ZERO_COUNT,
    input wire [7:0] STATE_MACHINE_ONE_COUNT,
    input wire [7:0] NEGATIVE_OPERAND,
    input wire [1:0] ROUTING_OPERAND_SELECT_PAIR,
    input wire RING_OSCILLATOR_CLOCK,
    input wire RC_OSCILLATOR_CLOCK,
    input wire ROUTING_CLOCK_INPUT,
    input wire POWER_DOWN_REQUEST,
    input wire SERIAL_PORT_CLOCK,
    input wire SERIAL_SELECT_N,
    input wire SERIAL_DATA_IN,
    output reg SERIAL_DATA_OUT,
    output reg SERIAL_DATA_OE_N,
    output reg [15:0] SERIAL_PARALLEL_OUT,
    output reg PWM_OUT,
    output reg COMPLEMENTARY_OUTPUT
);

// ****************************************
// helpers
// ****************************************
function [3:0] dead_cycles;
    input [2:0] code;
    reg [15:0] ns;
    reg [15:0] q;
    begin
        ns = ({13'h0000, code} + 16'h0001) * `PWC_DEAD_STEP_NS;
        q = (ns + `PWC_CLK_PERIOD_NS - 16'h0001) / `PWC_CLK_PERIOD_NS;
        dead_cycles = q[3:0];
    end
endfunction

function edge_to;
    input prev;
    input cur;
    input level;
    begin
        edge_to = (prev != cur) && (cur == level);
    end
endfunction

// ****************************************
// pin synchronisers
// ****************************************
localparam NSYNC = 9;
wire [NSYNC-1:0] pins;
reg [NSYNC-1:0] sync1;
reg [NSYNC-1:0] sync2;
reg [NSYNC-1:0] sync3;
reg [NSYNC-1:0] filt;
reg [NSYNC-1:0] filt_d;
integer i;

assign pins = {ROUTING_OPERAND_SELECT_PAIR, POWER_DOWN_REQUEST,
    SERIAL_DATA_IN, SERIAL_SELECT_N, SERIAL_PORT_CLOCK,
    ROUTING_CLOCK_INPUT, RC_OSCILLATOR_CLOCK, RING_OSCILLATOR_CLOCK};

always @(posedge MCLK or negedge RSTN)
begin
    if (!RSTN)
    begin
        sync1 <= `PWC_SYNC_RST;
        sync2 <= `PWC_SYNC_RST;
        sync3 <= `PWC_SYNC_RST;
        filt <= `PWC_SYNC_RST;
        filt_d <= `PWC_SYNC_RST;
    end
    else
    begin
        sync1 <= pins;
        sync2 <= sync1;
        sync3 <= sync2;
        filt_d <= filt;
        for (i = 0; i < NSYNC; i = i + 1)
            if (sync2[i] == sync3[i])
                filt[i] <= sync3[i];
    end
end

wire ring = filt[0];
wire rc = filt[1];
wire route_clk = filt[2];
wire sclk = filt[3];
wire sel_n = filt[4];
wire mosi = filt[5];
wire pd_pin = filt[6];
wire [1:0] route_sel = filt[8:7];

// ****************************************
// apb registers
// ****************************************
reg [15:0] cfg;
reg [7:0] ser;
reg [7:0] konst;
reg [7:0] cnt;
reg clk_en;
reg busy;
reg [31:0] rd_mux;
reg hit;
wire setup = PSEL & ~PENABLE;
wire wr = PSEL & PENABLE & PREADY & PWRITE & hit;

always @*
begin
    hit = (PADDR[1:0] == 2'h0);
    rd_mux = 32'h0000_0000;
    case (PADDR)
        `PWC_ADDR_CFG: rd_mux[15:0] = cfg;
        `PWC_ADDR_SERIAL: rd_mux[7:0] = ser;
        `PWC_ADDR_CONST: rd_mux[7:0] = konst;
        `PWC_ADDR_STATUS: rd_mux[11:0] = {busy, clk_en,
            COMPLEMENTARY_OUTPUT, PWM_OUT, cnt};
        `PWC_ADDR_PDATA: rd_mux[15:0] = SERIAL_PARALLEL_OUT;
        default: hit = 1'b0;
    endcase
end

always @(posedge MCLK or negedge RSTN)
begin
    if (!RSTN)
    begin
        PREADY <= 1'b0;
        PSLVERR <= 1'b0;
        PRDATA <= 32'h0000_0000;
        cfg <= `PWC_CFG_RST;
        ser <= `PWC_SER_RST;
        konst <= `PWC_CONST_RST;
    end
    else
    begin
        PREADY <= setup;
        PSLVERR <= setup & ~hit;
        PRDATA <= (setup & ~PWRITE) ? rd_mux : 32'h0000_0000;
        if (wr && PADDR == `PWC_ADDR_CFG)
            cfg <= PWDATA[15:0] & `PWC_CFG_MASK;
        if (wr && PADDR == `PWC_ADDR_SERIAL)
            ser <= PWDATA[7:0] & `PWC_SER_MASK;
        if (wr && PADDR == `PWC_ADDR_CONST)
            konst <= PWDATA[7:0]; // RULE11
    end
end

// ****************************************
// clock select and power-down
// ****************************************
reg shared_clk;
always @*
begin
    case (cfg[`PWC_F_SHARED]) // RULE18
        `PWC_SRC_RING: shared_clk = ring;
        `PWC_SRC_ROUTE: shared_clk = route_clk;
        `PWC_SRC_RC: shared_clk = rc;
        `PWC_SRC_SCLK: shared_clk = sclk;
        default: shared_clk = ring;
    endcase
end

reg sel_cur;
reg sel_prev;
always @*
begin
    sel_cur = cfg[`PWC_F_CLKSRC] ? route_clk : shared_clk;
    sel_prev = filt_d[0];
    if (cfg[`PWC_F_CLKSRC])
        sel_prev = filt_d[2];
    else
        case (cfg[`PWC_F_SHARED])
            `PWC_SRC_ROUTE: sel_prev = filt_d[2];
            `PWC_SRC_RC: sel_prev = filt_d[1];
            `PWC_SRC_SCLK: sel_prev = filt_d[3];
            default: sel_prev = filt_d[0];
        endcase
end

// inversion counts the falling edge instead of the rising one
wire raw_tick = edge_to(sel_prev, sel_cur, ~cfg[`PWC_F_CLKINV]); // RULE5
wire pd = pd_pin & ~cfg[`PWC_F_FORCEON]; // RULE9
wire pd_sync = cfg[`PWC_F_PDSYNC];
reg [1:0] wake;
wire awake = (wake == `PWC_WAKE_CYCLES);

always @(posedge MCLK or negedge RSTN)
begin
    if (!RSTN)
        wake <= 2'h0;
    else if (pd)
        wake <= 2'h0; // RULE8
    else if (raw_tick && !awake)
        wake <= wake + 2'h1; // RULE7
end

always @*
begin
    if (pd)
        clk_en = 1'b0; // RULE6 RULE8
    else if (pd_sync)
        clk_en = awake; // RULE7
    else
        clk_en = 1'b1;
end

wire tick = raw_tick & clk_en;

// ****************************************
// serial port
// ****************************************
wire cpol = ser[`PWC_S_CPOL];
wire cpha = ser[`PWC_S_CPHA];
wire byte_mode = ser[`PWC_S_BYTE];
wire dir_out = ser[`PWC_S_DIR];
// leading edge leaves the idle level, trailing edge returns to it
wire lead = edge_to(filt_d[3], sclk, ~cpol) & busy; // RULE15
wire trail = edge_to(filt_d[3], sclk, cpol) & busy; // RULE15
wire sample = cpha ? trail : lead; // RULE14
wire shift = cpha ? lead : trail; // RULE14
wire sel_fall = filt_d[4] & ~sel_n;
wire [4:0] xfer_len = byte_mode ? `PWC_LEN_BYTE : `PWC_LEN_WORD; // RULE16
reg [15:0] out_sr;
reg [15:0] in_sr;
reg [4:0] bits;
reg [7:0] adc_q;
wire [15:0] par_src = ser[`PWC_S_PARSRC] ? {8'h00, ADC_RESULT} :
    {STATE_MACHINE_ZERO_COUNT, STATE_MACHINE_ONE_COUNT}; // RULE13
wire [15:0] in_next = {in_sr[14:0], mosi};

always @(posedge MCLK or negedge RSTN)
begin
    if (!RSTN)
    begin
        busy <= 1'b0;
        bits <= 5'h00;
        out_sr <= 16'h0000;
        in_sr <= 16'h0000;
        adc_q <= 8'h00;
        SERIAL_PARALLEL_OUT <= 16'h0000;
        SERIAL_DATA_OUT <= 1'b0;
        SERIAL_DATA_OE_N <= 1'b1;
    end
    else
    begin
        adc_q <= ADC_RESULT;
        SERIAL_DATA_OUT <= byte_mode ? out_sr[7] : out_sr[15]; // RULE16
        SERIAL_DATA_OE_N <= sel_n | ~dir_out | ~busy; // RULE17
        if (sel_n)
            busy <= 1'b0; // RULE22
        else if (sel_fall)
        begin
            busy <= 1'b1;
            bits <= 5'h00;
            out_sr <= par_src; // RULE17
        end
        else
        begin
            // first bit is already on the line at the first lead edge
            if (shift && bits != 5'h00 && dir_out)
                out_sr <= {out_sr[14:0], 1'b0}; // RULE17
            if (sample)
            begin
                in_sr <= in_next;
                bits <= bits + 5'h01;
                if (bits + 5'h01 == xfer_len)
                begin
                    busy <= 1'b0; // RULE16
                    if (!dir_out && !ser[`PWC_S_BUFEN])
                        SERIAL_PARALLEL_OUT <= byte_mode ?
                            {8'h00, in_next[7:0]} : in_next; // RULE17
                end
            end
        end
        if (ser[`PWC_S_BUFEN])
            SERIAL_PARALLEL_OUT <= {8'h00, adc_q}; // RULE12
    end
end

wire [7:0] upper_byte = SERIAL_PARALLEL_OUT[15:8];

// ****************************************
// operand select
// ****************************************
reg [7:0] live_op;
reg [7:0] pos_live;
always @*
begin
    case (route_sel)
        `PWC_POS_ADC: live_op = ADC_RESULT;
        `PWC_POS_UPPER: live_op = upper_byte;
        `PWC_POS_FSM0: live_op = STATE_MACHINE_ZERO_COUNT;
        `PWC_POS_CONST: live_op = konst;
        default: live_op = ADC_RESULT;
    endcase
    case (cfg[`PWC_F_POSSEL]) // RULE10
        `PWC_POS_ADC: pos_live = ADC_RESULT;
        `PWC_POS_UPPER: pos_live = upper_byte;
        `PWC_POS_FSM0: pos_live = STATE_MACHINE_ZERO_COUNT;
        `PWC_POS_LIVE: pos_live = live_op;
        default: pos_live = ADC_RESULT;
    endcase
end

// ****************************************
// modulator and comparator
// ****************************************
reg [7:0] op;
reg [3:0] dead;
reg level;
wire mode = cfg[`PWC_F_MODE];
wire cmp_func = cfg[`PWC_F_FUNC];
wire sclk_rise = edge_to(filt_d[3], sclk, 1'b1);
wire pwm_raw = mode ? (cnt <= op) : (cnt < op); // RULE2 RULE3 RULE21
wire match = mode ? (pos_live >= NEGATIVE_OPERAND) :
    (pos_live > NEGATIVE_OPERAND); // RULE2 RULE3

always @(posedge MCLK or negedge RSTN)
begin
    if (!RSTN)
    begin
        cnt <= 8'h00;
        op <= 8'h00;
    end
    else if (!pd_sync && pd)
        cnt <= 8'h00; // RULE6
    else
    begin
        if (tick)
            cnt <= cnt + 8'h01; // RULE21
        if (cfg[`PWC_F_OPSYNC])
        begin
            if (sclk_rise)
                op <= pos_live; // RULE19
        end
        else if (tick && cnt == `PWC_CNT_TOP)
            op <= pos_live; // RULE21
    end
end

always @(posedge MCLK or negedge RSTN)
begin
    if (!RSTN)
    begin
        dead <= 4'h0;
        level <= 1'b0;
        PWM_OUT <= 1'b0;
        COMPLEMENTARY_OUTPUT <= 1'b0;
    end
    else if (!pd_sync && pd)
    begin
        dead <= 4'h0;
        level <= 1'b0;
        PWM_OUT <= 1'b0; // RULE6
        COMPLEMENTARY_OUTPUT <= 1'b0; // RULE6
    end
    else if (!clk_en)
    begin
        PWM_OUT <= PWM_OUT; // RULE8
    end
    else if (cmp_func)
    begin
        dead <= 4'h0;
        PWM_OUT <= match;
        COMPLEMENTARY_OUTPUT <= match; // RULE4
    end
    else if (dead != 4'h0)
    begin
        dead <= dead - 4'h1; // RULE1
        if (dead == 4'h1)
        begin
            PWM_OUT <= level;
            COMPLEMENTARY_OUTPUT <= ~level; // RULE4
        end
    end
    else if (pwm_raw != level || PWM_OUT == COMPLEMENTARY_OUTPUT)
    begin
        level <= pwm_raw;
        dead <= dead_cycles(cfg[`PWC_F_DEAD]); // RULE1
        PWM_OUT <= 1'b0; // RULE20
        COMPLEMENTARY_OUTPUT <= 1'b0; // RULE20
    end
end

endmodule // pwc_channel

// >>> core/pwc_map.vh
`ifndef PWC_MAP_VH
`define PWC_MAP_VH

// ****************************************
// apb register offsets
// ****************************************
`define PWC_ADDR_CFG 8'h00
`define PWC_ADDR_SERIAL 8'h04
`define PWC_ADDR_CONST 8'h08
`define PWC_ADDR_STATUS 8'h0C
`define PWC_ADDR_PDATA 8'h10

// ****************************************
// channel config fields
// ****************************************
`define PWC_F_DEAD 2:0
`define PWC_F_MODE 3
`define PWC_F_FUNC 4
`define PWC_F_CLKSRC 5
`define PWC_F_CLKINV 6
`define PWC_F_PDSYNC 7
`define PWC_F_FORCEON 8
`define PWC_F_POSSEL 10:9
`define PWC_F_SHARED 12:11
`define PWC_F_OPSYNC 13
`define PWC_CFG_RST 16'h0000
`define PWC_CFG_MASK 16'h3FFF

// ****************************************
// serial port config fields
// ****************************************
`define PWC_S_BUFEN 0
`define PWC_S_PARSRC 1
`define PWC_S_CPHA 2
`define PWC_S_CPOL 3
`define PWC_S_BYTE 4
`define PWC_S_DIR 5
`define PWC_SER_RST 8'h00
`define PWC_SER_MASK 8'h3F
`define PWC_CONST_RST 8'h00

// ****************************************
// encodings
// ****************************************
`define PWC_SRC_RING 2'h0
`define PWC_SRC_ROUTE 2'h1
`define PWC_SRC_RC 2'h2
`define PWC_SRC_SCLK 2'h3
`define PWC_POS_ADC 2'h0
`define PWC_POS_UPPER 2'h1
`define PWC_POS_FSM0 2'h2
`define PWC_POS_LIVE 2'h3
`define PWC_POS_CONST 2'h3

// ****************************************
// timing
// ****************************************
`define PWC_CLK_PERIOD_NS 16'h0064
`define PWC_DEAD_STEP_NS 16'h000A
`define PWC_WAKE_CYCLES 2'h2
`define PWC_LEN_WORD 5'h10
`define PWC_LEN_BYTE 5'h08
`define PWC_CNT_TOP 8'hFF
// select input idles high, so its stages start high
`define PWC_SYNC_RST 9'h010

`endif

// >>> verif/pwc_channel_asserts.sv
module pwc_channel_asserts
(
    input wire MCLK,
    input wire RSTN,
    input wire PSEL,
    input wire PENABLE,
    input wire [7:0] PADDR,
    input wire [31:0] PRDATA,
    input wire PREADY,
    input wire PSLVERR,
    input wire PWM_OUT,
    input wire COMPLEMENTARY_OUTPUT,
    input wire SERIAL_SELECT_N,
    input wire SERIAL_DATA_OE_N
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RSTN);
    wire bad = PADDR > 8'h10 || PADDR[1:0] != 2'b00;
    sequence apb_setup;
        PSEL && !PENABLE;
    endsequence
    sequence apb_answer;
        PSEL && PENABLE && PREADY;
    endsequence
    chk_zero_wait: assert property (apb_setup |=> apb_answer)
        else $error("no zero-wait answer");
    chk_ready_single: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    chk_err_addr: assert property (PREADY && bad |-> PSLVERR)
        else $error("bad address not refused");
    chk_err_only: assert property (PSLVERR |-> PREADY && bad)
        else $error("error without cause");
    chk_idle_zero: assert property (!PREADY |-> PRDATA == 32'h0000_0000)
        else $error("read data outside access");
    chk_dead_pwm: assert property ($rose(PWM_OUT) && !COMPLEMENTARY_OUTPUT |-> !$past(COMPLEMENTARY_OUTPUT))
        else $error("true output rose without dead band");
    chk_dead_comp: assert property ($rose(COMPLEMENTARY_OUTPUT) && !PWM_OUT |-> !$past(PWM_OUT))
        else $error("complement rose without dead band");
    chk_oe_idle: assert property (SERIAL_SELECT_N [*6] |-> SERIAL_DATA_OE_N)
        else $error("data driven while deselected");
endmodule // pwc_channel_asserts

// >>> verif/pwc_serial_master.sv
module pwc_serial_master
(
    input wire go,
    input wire cpol,
    input wire cpha,
    input wire [4:0] len,
    input wire [15:0] tx,
    input wire miso,
    output reg sclk,
    output reg sel_n,
    output reg mosi,
    output reg [15:0] rx,
    output reg done
);
    timeunit 1ns;
    timeprecision 1ns;
    integer i;
    initial
    begin
        sclk = 1'b0;
        sel_n = 1'b1;
        mosi = 1'b0;
        rx = 16'h0000;
        done = 1'b0;
    end
    always @(cpol)
        if (sel_n)
            sclk = cpol;
    always @(posedge go)
    begin
        // keep every pin change off the sampling edge
        #25;
        done = 1'b0;
        rx = 16'h0000;
        sel_n = 1'b0;
        #800;
        for (i = len - 1; i >= 0; i = i - 1)
        begin
            if (!cpha)
                mosi = tx[i];
            #400 sclk = ~cpol;
            // slave output trails its edges by several clocks: sample late
            if (cpha && i != len - 1)
                rx = {rx[14:0], miso};
            if (cpha)
                mosi = tx[i];
            #400 sclk = cpol;
            if (!cpha)
                rx = {rx[14:0], miso};
        end
        #400;
        if (cpha)
            rx = {rx[14:0], miso};
        #400 sel_n = 1'b1;
        mosi = ~mosi;
        done = 1'b1;
    end
endmodule // pwc_serial_master

// >>> verif/pwc_channel_test.sv
`include "pwc_map.vh"
module pwc_channel_test;
    timeunit 1ns;
    timeprecision 1ns;
    reg mclk, rstn, psel, penable, pwrite, ring, pd, go, cpol, cpha, er;
    reg [7:0] paddr, adc, fsm0, fsm1, neg;
    reg [1:0] pair;
    reg [4:0] len;
    reg [15:0] tx;
    reg [31:0] pwdata, rd;
    wire [31:0] prdata;
    wire pready, pslverr, sclk, sel_n, mosi, dout, oe_n, pwm, cmpo, done;
    wire [15:0] pout, rx;
    wire miso = oe_n ? ~dout : dout;
    integer err_total, checks, cyc, n, k;
    pwc_channel u_dut
    (
        .MCLK(mclk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .ADC_RESULT(adc),
        .STATE_MACHINE_ZERO_COUNT(fsm0), .STATE_MACHINE_ONE_COUNT(fsm1),
        .NEGATIVE_OPERAND(neg), .ROUTING_OPERAND_SELECT_PAIR(pair),
        .RING_OSCILLATOR_CLOCK(ring), .RC_OSCILLATOR_CLOCK(ring),
        .ROUTING_CLOCK_INPUT(ring), .POWER_DOWN_REQUEST(pd),
        .SERIAL_PORT_CLOCK(sclk), .SERIAL_SELECT_N(sel_n),
        .SERIAL_DATA_IN(mosi), .SERIAL_DATA_OUT(dout),
        .SERIAL_DATA_OE_N(oe_n), .SERIAL_PARALLEL_OUT(pout),
        .PWM_OUT(pwm), .COMPLEMENTARY_OUTPUT(cmpo)
    );
    pwc_serial_master u_master
    (
        .go(go), .cpol(cpol), .cpha(cpha), .len(len), .tx(tx),
        .miso(miso), .sclk(sclk), .sel_n(sel_n), .mosi(mosi), .rx(rx),
        .done(done)
    );
    // ****************************************
    // clocks and tasks
    // ****************************************
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial
    begin
        ring = 1'b0;
        #30;
        forever #400 ring = ~ring;
    end
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 80000)
        begin
            err_total = err_total + 1;
            $display("wrong value at %0t: timeout", $time);
            summarize;
        end
    end
    task summarize;
        if (err_total == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task cmp(input [31:0] got, input [31:0] exp);
        checks = checks + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task xfer(input [5:0] s, input [15:0] t, input [15:0] e);
        apb(1'b1, `PWC_ADDR_SERIAL, {26'h0, s});
        cpol <= s[3];
        cpha <= s[2];
        len <= s[4] ? 5'd8 : 5'd16;
        tx <= t;
        repeat (8) @(posedge mclk);
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        @(posedge done);
        repeat (10) @(posedge mclk);
        apb(1'b0, `PWC_ADDR_PDATA, 32'h0000_0000);
        cmp(s[5] ? rx : rd[15:0], e);
    endtask
    task duty(input [15:0] c, input [7:0] op, input [11:0] eh, input [11:0] el);
        apb(1'b1, `PWC_ADDR_CONST, {24'h0, op});
        apb(1'b1, `PWC_ADDR_CFG, {16'h0, c});
        repeat (4200) @(posedge mclk);
        n = 0;
        k = 0;
        repeat (2048)
        begin
            @(posedge mclk);
            n = n + pwm;
            k = k + cmpo;
        end
        cmp(n, eh);
        cmp(k, el);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        {rstn, psel, penable, pwrite, pd, go, cpol, cpha} = 8'h00;
        {paddr, adc, fsm0, fsm1, neg} = 40'h00_0000_0000;
        {pair, len, tx, pwdata} = 55'h0;
        err_total = 0;
        checks = 0;
        cyc = 0;
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        for (k = 0; k < 3; k = k + 1)
        begin
            apb(1'b0, 8'(k * 4), 32'h0000_0000);
            cmp(rd, 32'h0000_0000);
            apb(1'b1, 8'(k * 4), 32'hFFFF_FFFF);
            apb(1'b0, 8'(k * 4), 32'h0000_0000);
            cmp(rd, k == 0 ? 32'h3FFF : k == 1 ? 32'h3F : 32'hFF);
        end
        apb(1'b0, 8'h14, 32'h0000_0000);
        cmp(er, 1'b1);
        neg <= 8'h40;
        for (k = 0; k < 6; k = k + 1)
        begin
            adc <= 8'(8'h3F + k % 3);
            apb(1'b1, `PWC_ADDR_CFG, 32'h10 | 32'((k / 3) << 3));
            repeat (8) @(posedge mclk);
            cmp(cmpo, k % 3 == 2 || (k >= 3 && k % 3 == 1));
        end
        {adc, fsm0, fsm1} <= 24'h90_1234;
        xfer(6'h1C, 16'h003C, 16'h003C);
        xfer(6'h20, 16'h0000, 16'h1234);
        xfer(6'h3A, 16'h0000, 16'h0090);
        xfer(6'h00, 16'hA55A, 16'hA55A);
        neg <= 8'h80;
        for (k = 0; k < 5; k = k + 1)
        begin
            pair <= 2'(k);
            apb(1'b1, `PWC_ADDR_CFG, k < 4 ? 32'h0610 : 32'h0410);
            repeat (8) @(posedge mclk);
            cmp(cmpo, (5'b01011 >> k) & 1);
        end
        pair <= 2'h3;
        duty(16'h0607, 8'h80, 12'd1023, 12'd1023);
        duty(16'h0600, 8'h00, 12'd0, 12'd2048);
        duty(16'h0608, 8'hFF, 12'd2048, 12'd0);
        duty(16'h0608, 8'h80, 12'd1031, 12'd1015);
        duty(16'h0600, 8'h80, 12'd1023, 12'd1023);
        duty(16'h1600, 8'h80, 12'd1023, 12'd1023);
        duty(16'h0620, 8'h80, 12'd1023, 12'd1023);
        pd <= 1'b1;
        repeat (10) @(posedge mclk);
        cmp({pwm, cmpo}, 2'b00);
        duty(16'h0740, 8'h80, 12'd1023, 12'd1023);
        pd <= 1'b0;
        duty(16'h0680, 8'h80, 12'd1023, 12'd1023);
        pd <= 1'b1;
        repeat (10) @(posedge mclk);
        n = {pwm, cmpo};
        repeat (2048) @(posedge mclk);
        cmp({pwm, cmpo}, n);
        apb(1'b0, `PWC_ADDR_STATUS, 32'h0000_0000);
        cmp(rd[10], 1'b0);
        pd <= 1'b0;
        repeat (5) @(posedge mclk);
        apb(1'b0, `PWC_ADDR_STATUS, 32'h0000_0000);
        cmp(rd[10], 1'b0);
        repeat (30) @(posedge mclk);
        apb(1'b0, `PWC_ADDR_STATUS, 32'h0000_0000);
        cmp(rd[10], 1'b1);
        apb(1'b1, `PWC_ADDR_SERIAL, 32'h1);
        adc <= 8'h5B;
        repeat (6) @(posedge mclk);
        apb(1'b0, `PWC_ADDR_PDATA, 32'h0000_0000);
        cmp(rd, 32'h5B);
        summarize;
    end
endmodule // pwc_channel_test
bind pwc_channel pwc_channel_asserts u_chk
(
    .MCLK(MCLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PWM_OUT(PWM_OUT), .COMPLEMENTARY_OUTPUT(COMPLEMENTARY_OUTPUT),
    .SERIAL_SELECT_N(SERIAL_SELECT_N), .SERIAL_DATA_OE_N(SERIAL_DATA_OE_N)
);
